// ---- pkg/pmt_pkg.sv ----
// Purpose: Constants and types for the power event, control and timer register bank
// Assumes: Byte-wide system I/O accesses relative to a programmable base
// Notes: Constants, field positions and the state record of the bank
package pmt_pkg;

  localparam int unsigned TMR_W        = 24;
  localparam real         TMR_FREQ_MHZ = 3.579545;

  localparam logic [15:0] BLK_SIZE     = 16'h000c;
  localparam logic [3:0]  OFS_STS_LOW  = 4'h0;
  localparam logic [3:0]  OFS_STS_HIGH = 4'h1;
  localparam logic [3:0]  OFS_EN_LOW   = 4'h2;
  localparam logic [3:0]  OFS_EN_HIGH  = 4'h3;
  localparam logic [3:0]  OFS_CTL0     = 4'h4;
  localparam logic [3:0]  OFS_CTL1     = 4'h5;
  localparam logic [3:0]  OFS_CTL2     = 4'h6;
  localparam logic [3:0]  OFS_CTL3     = 4'h7;
  localparam logic [3:0]  OFS_TMR0     = 4'h8;
  localparam logic [3:0]  OFS_TMR1     = 4'h9;
  localparam logic [3:0]  OFS_TMR2     = 4'ha;
  localparam logic [3:0]  OFS_TMR3     = 4'hb;

  localparam int unsigned BIT_TMR      = 0;
  localparam int unsigned BIT_BM_STS   = 4;
  localparam int unsigned BIT_GBL      = 5;
  localparam int unsigned BIT_WAK      = 7;
  localparam int unsigned BIT_ROUTE    = 0;
  localparam int unsigned BIT_RELOAD   = 1;
  localparam int unsigned BIT_GRELEASE = 2;
  localparam int unsigned BIT_CARRY    = 23;

  localparam logic [7:0]  RESET_BYTE   = 8'h00;

  typedef enum logic [0:0]
  {
    PMT_WORKING  = 1'b0,
    PMT_SLEEPING = 1'b1
  } pmt_mode_e;

  typedef struct packed
  {
    pmt_mode_e          mode;
    logic [TMR_W-1:0]   timer_count_value;
    logic               clk_prev;
    logic               timer_carry_status;
    logic               bus_master_status;
    logic               global_event_status;
    logic               wake_status;
    logic               timer_carry_enable;
    logic               global_event_enable;
    logic               interrupt_route_select;
    logic               bus_master_reload_enable;
    logic               global_release;
    logic               firmware_status;
    logic               firmware_release;
    logic               bus_master_control;
    logic [7:0]         rdata;
    logic               rd_ack;
    logic               sci_n;
    logic               smi_n;
  } pmt_state_s;

endpackage

// ---- design/pmt_bank.sv ----
// Purpose: Power event, control and timer register bank in system I/O space
// Assumes: All inputs synchronous to mclk_in; input_clock_in sampled at 100 MHz
// Notes: Reads answer one cycle after the strobe; reads have no side effects
`timescale 1ns/1ps
module pmt_bank
  import pmt_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk_in,
  input  wire logic        rstn_in,
  // System I/O bus
  input  wire logic [15:0] io_addr_in,
  input  wire logic        io_rd_in,
  input  wire logic        io_wr_in,
  input  wire logic [7:0]  io_wdata_in,
  input  wire logic [15:0] io_base_in,
  output logic      [7:0]  io_rdata_out,
  output logic             io_rd_ack_out,
  // Timer clock
  input  wire logic        input_clock_in,
  // Sleep control
  input  wire logic        resume_event_in,
  input  wire logic        standby_expired_in,
  input  wire logic        all_devices_sleep_in,
  output logic             sleeping_out,
  // Firmware side
  input  wire logic        mgmt_interrupt_enable_in,
  input  wire logic        firmware_enable_in,
  input  wire logic        firmware_release_set_in,
  input  wire logic        firmware_status_clr_in,
  input  wire logic        bus_master_control_set_in,
  output logic             firmware_status_out,
  // Interrupts, active low
  output logic             sci_n_out,
  output logic             smi_n_out
);

  pmt_state_s q;
  pmt_state_s d;

  logic [15:0] offset;
  logic        hit;
  logic        wr_hit;
  logic        tick;
  logic        pm_event;
  logic [3:0]  ofs;

  assign offset = io_addr_in - io_base_in;
  assign hit    = (offset < BLK_SIZE);
  assign ofs    = offset[3:0];
  assign wr_hit = io_wr_in && hit;
  assign tick   = input_clock_in && !q.clk_prev;

  always_comb
  begin
    d          = q;
    d.clk_prev = input_clock_in;
    // Timer advances on each rising input clock edge while working
    if (tick && (q.mode == PMT_WORKING))
    begin
      d.timer_count_value = q.timer_count_value + 24'h000001;
    end
    // Status clears by write one
    if (wr_hit && (ofs == OFS_STS_LOW))
    begin
      if (io_wdata_in[BIT_TMR])
      begin
        d.timer_carry_status = 1'b0;
      end
      if (io_wdata_in[BIT_BM_STS])
      begin
        d.bus_master_status  = 1'b0;
        d.bus_master_control = 1'b0;
      end
      if (io_wdata_in[BIT_GBL])
      begin
        d.global_event_status = 1'b0;
        d.firmware_release    = 1'b0;
      end
    end
    if ((wr_hit && (ofs == OFS_STS_HIGH) && io_wdata_in[BIT_WAK]) || standby_expired_in)
    begin
      d.wake_status = 1'b0;
    end
    if (wr_hit && (ofs == OFS_EN_LOW))
    begin
      d.timer_carry_enable  = io_wdata_in[BIT_TMR];
      d.global_event_enable = io_wdata_in[BIT_GBL];
    end
    if (firmware_status_clr_in)
    begin
      d.firmware_status = 1'b0;
      d.global_release  = 1'b0;
    end
    if (wr_hit && (ofs == OFS_CTL0))
    begin
      d.interrupt_route_select   = io_wdata_in[BIT_ROUTE];
      d.bus_master_reload_enable = io_wdata_in[BIT_RELOAD];
      if (io_wdata_in[BIT_GRELEASE])
      begin
        d.global_release  = 1'b1;
        d.firmware_status = 1'b1;
      end
    end
    // Hardware sets win over clears
    if (d.timer_count_value[BIT_CARRY] != q.timer_count_value[BIT_CARRY])
    begin
      d.timer_carry_status = 1'b1;
    end
    if (bus_master_control_set_in)
    begin
      d.bus_master_control = 1'b1;
      d.bus_master_status  = 1'b1;
    end
    if (firmware_release_set_in)
    begin
      d.firmware_release    = 1'b1;
      d.global_event_status = 1'b1;
    end
    unique case (q.mode)
      PMT_SLEEPING:
      begin
        if (resume_event_in)
        begin
          d.wake_status = 1'b1;
          d.mode        = PMT_WORKING;
        end
      end
      PMT_WORKING:
      begin
        if (!q.wake_status && all_devices_sleep_in)
        begin
          d.mode = PMT_SLEEPING;
        end
      end
    endcase
    // Event routing
    pm_event = (d.timer_carry_enable && d.timer_carry_status)
             || (d.global_event_enable && d.global_event_status)
             || (d.bus_master_reload_enable && d.bus_master_control);
    d.sci_n  = !(d.interrupt_route_select && pm_event);
    d.smi_n  = !((!d.interrupt_route_select && mgmt_interrupt_enable_in && pm_event)
             || (d.global_release && firmware_enable_in));
    // Register read, reserved bits zero
    d.rd_ack = io_rd_in && hit;
    d.rdata  = RESET_BYTE;
    if (io_rd_in && hit)
    begin
      unique case (ofs)
        OFS_STS_LOW:
        begin
          d.rdata = {2'b00, q.global_event_status, q.bus_master_status,
                     3'b000, q.timer_carry_status};
        end
        OFS_STS_HIGH:
        begin
          d.rdata = {q.wake_status, 7'h00};
        end
        OFS_EN_LOW:
        begin
          d.rdata = {2'b00, q.global_event_enable, 4'h0, q.timer_carry_enable};
        end
        OFS_CTL0:
        begin
          d.rdata = {5'h00, q.global_release, q.bus_master_reload_enable,
                     q.interrupt_route_select};
        end
        OFS_TMR0:
        begin
          d.rdata = q.timer_count_value[7:0];
        end
        OFS_TMR1:
        begin
          d.rdata = q.timer_count_value[15:8];
        end
        OFS_TMR2:
        begin
          d.rdata = q.timer_count_value[23:16];
        end
        default:
        begin
          d.rdata = RESET_BYTE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      q       <= '0;
      q.sci_n <= 1'b1;
      q.smi_n <= 1'b1;
    end
    else
    begin
      q <= d;
    end
  end

  assign io_rdata_out        = q.rdata;
  assign io_rd_ack_out       = q.rd_ack;
  assign sleeping_out        = q.mode;
  assign firmware_status_out = q.firmware_status;
  assign sci_n_out           = q.sci_n;
  assign smi_n_out           = q.smi_n;

  property p_wake_set;
    @(posedge mclk_in) disable iff (!rstn_in)
    (q.mode == PMT_SLEEPING && resume_event_in) |=> (q.wake_status && q.mode == PMT_WORKING);
  endproperty
  a_wake_set: assert property (p_wake_set) else $error("Wake not set on resume");

  property p_wake_only_hw;
    @(posedge mclk_in) disable iff (!rstn_in)
    $rose(q.wake_status) |-> (($past(q.mode) == PMT_SLEEPING) && $past(resume_event_in));
  endproperty
  a_wake_only_hw: assert property (p_wake_only_hw) else $error("Wake set without cause");

  property p_wake_clear;
    @(posedge mclk_in) disable iff (!rstn_in)
    (standby_expired_in && !(q.mode == PMT_SLEEPING && resume_event_in)) |=> !q.wake_status;
  endproperty
  a_wake_clear: assert property (p_wake_clear) else $error("Wake not cleared");

  property p_sleep_entry;
    @(posedge mclk_in) disable iff (!rstn_in)
    (q.mode == PMT_WORKING && !q.wake_status && all_devices_sleep_in) |=> sleeping_out;
  endproperty
  a_sleep_entry: assert property (p_sleep_entry) else $error("Chip did not sleep");

  property p_carry_edge;
    @(posedge mclk_in) disable iff (!rstn_in)
    ($past(q.timer_count_value[BIT_CARRY]) != q.timer_count_value[BIT_CARRY])
      |-> q.timer_carry_status;
  endproperty
  a_carry_edge: assert property (p_carry_edge) else $error("Carry status missed");

  property p_timer_hold;
    @(posedge mclk_in) disable iff (!rstn_in)
    (!tick || q.mode == PMT_SLEEPING) |=> $stable(q.timer_count_value);
  endproperty
  a_timer_hold: assert property (p_timer_hold) else $error("Timer moved without tick");

  property p_timer_step;
    @(posedge mclk_in) disable iff (!rstn_in)
    (tick && q.mode == PMT_WORKING)
      |=> (q.timer_count_value == $past(q.timer_count_value) + 24'h000001);
  endproperty
  a_timer_step: assert property (p_timer_step) else $error("Timer did not count");

  property p_sci_timer;
    @(posedge mclk_in) disable iff (!rstn_in)
    (q.interrupt_route_select && q.timer_carry_enable && q.timer_carry_status) |-> !sci_n_out;
  endproperty
  a_sci_timer: assert property (p_sci_timer) else $error("Timer SCI missing");

  property p_no_sci_unrouted;
    @(posedge mclk_in) disable iff (!rstn_in)
    !q.interrupt_route_select |-> sci_n_out;
  endproperty
  a_no_sci_unrouted: assert property (p_no_sci_unrouted) else $error("SCI while unrouted");

  property p_release_smi;
    @(posedge mclk_in) disable iff (!rstn_in)
    (wr_hit && ofs == OFS_CTL0 && io_wdata_in[BIT_GRELEASE] && firmware_enable_in)
      ##1 firmware_enable_in |-> (firmware_status_out && !smi_n_out);
  endproperty
  a_release_smi: assert property (p_release_smi) else $error("Release SMI missing");

  property p_rsvd_read;
    @(posedge mclk_in) disable iff (!rstn_in)
    (io_rd_in && hit && ofs == OFS_EN_HIGH) |=> (io_rd_ack_out && io_rdata_out == 8'h00);
  endproperty
  a_rsvd_read: assert property (p_rsvd_read) else $error("Reserved read nonzero");

  property p_tmr_read;
    @(posedge mclk_in) disable iff (!rstn_in)
    (io_rd_in && hit && ofs == OFS_TMR1) |=> (io_rdata_out == $past(q.timer_count_value[15:8]));
  endproperty
  a_tmr_read: assert property (p_tmr_read) else $error("Timer byte wrong");

endmodule

// ---- verification/pmt_bank_bench.sv ----
// Purpose: Self-checking bench for the power event, control and timer register bank
// Assumes: Byte I/O strobes one cycle wide; timer clock driven slowly by the bench
// Notes: Bit 23 carry needs 2^23 timer edges and is left to the design's own assertions
`timescale 1ns/1ps
module pmt_bank_bench;
  import pmt_pkg::*;
  logic        mclk_in;
  logic        rstn_in;
  logic [15:0] io_addr;
  logic        io_rd;
  logic        io_wr;
  logic [7:0]  io_wdata;
  logic [7:0]  io_rdata;
  logic        io_ack;
  logic        tclk;
  logic [4:0]  ev;
  logic        all_sleep;
  logic        sleeping;
  logic        mgmt_en;
  logic        fw_en;
  logic        fw_status;
  logic        sci_n;
  logic        smi_n;
  int          num_errors;
  int          total_checks;
  int          cycles;
  localparam logic [15:0] BASE = 16'h0e00;

  pmt_bank pmt_bank_i (
    .mclk_in(mclk_in), .rstn_in(rstn_in), .io_addr_in(io_addr), .io_rd_in(io_rd),
    .io_wr_in(io_wr), .io_wdata_in(io_wdata), .io_base_in(BASE), .io_rdata_out(io_rdata),
    .io_rd_ack_out(io_ack), .input_clock_in(tclk), .resume_event_in(ev[0]),
    .standby_expired_in(ev[1]), .all_devices_sleep_in(all_sleep), .sleeping_out(sleeping),
    .mgmt_interrupt_enable_in(mgmt_en), .firmware_enable_in(fw_en),
    .firmware_release_set_in(ev[2]), .firmware_status_clr_in(ev[3]),
    .bus_master_control_set_in(ev[4]), .firmware_status_out(fw_status),
    .sci_n_out(sci_n), .smi_n_out(smi_n));

  initial
  begin
    mclk_in = 1'b0;
    forever #5 mclk_in = ~mclk_in;
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  always @(posedge mclk_in)
  begin
    cycles <= cycles + 1;
    if (cycles == 30000)
    begin
      num_errors++;
      end_sim();
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
    end
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge mclk_in);
  endtask

  task automatic io_write(input logic [15:0] off, input logic [7:0] d);
    @(posedge mclk_in);
    io_addr  <= BASE + off;
    io_wdata <= d;
    io_wr    <= 1'b1;
    @(posedge mclk_in);
    io_wr    <= 1'b0;
  endtask

  // Reads give an ack and data for one cycle, sampled mid-cycle
  task automatic io_read(input logic [15:0] off, input logic [7:0] exp, input logic hit);
    logic got;
    got = 1'b0;
    @(posedge mclk_in);
    io_addr <= BASE + off;
    io_rd   <= 1'b1;
    @(posedge mclk_in);
    io_rd   <= 1'b0;
    repeat (3)
    begin
      @(negedge mclk_in);
      if (io_ack === 1'b1 && !got)
      begin
        got = 1'b1;
        check(io_rdata, exp);
      end
    end
    check({7'h00, got}, {7'h00, hit});
  endtask

  task automatic pulse(input int i);
    @(posedge mclk_in);
    ev[i] <= 1'b1;
    @(posedge mclk_in);
    ev[i] <= 1'b0;
    wait_cyc(3);
  endtask

  // Timer clock near 3.58 MHz: 14 cycles high, 14 low
  task automatic tick(input int n);
    repeat (n)
    begin
      wait_cyc(14);
      tclk <= 1'b1;
      wait_cyc(14);
      tclk <= 1'b0;
    end
    wait_cyc(3);
  endtask

  task automatic pins(input logic sci, input logic smi);
    check({6'h00, sci_n, smi_n}, {6'h00, sci, smi});
  endtask

  initial
  begin
    {io_addr, io_rd, io_wr, io_wdata, tclk, ev, all_sleep, mgmt_en, fw_en} = '0;
    {num_errors, total_checks, cycles} = '0;
    rstn_in = 1'b0;
    wait_cyc(2);
    rstn_in <= 1'b1;
    for (int a = 1; a < 12; a++) io_read(a, RESET_BYTE, 1'b1);
    io_read(16'h000c, 8'h00, 1'b0);
    $display("test reset done");
    for (int a = 2; a < 8; a++) io_write(a, 8'hff);
    io_read(2, 8'h21, 1'b1);
    io_read(3, 8'h00, 1'b1);
    io_read(4, 8'h07, 1'b1);
    for (int a = 5; a < 8; a++) io_read(a, 8'h00, 1'b1);
    check({7'h00, fw_status}, 8'h01);
    pins(1'b1, 1'b1);
    pulse(3);
    io_read(4, 8'h03, 1'b1);
    $display("test registers done");
    pulse(2);
    io_read(0, 8'h20, 1'b1);
    pins(1'b0, 1'b1);
    io_write(0, 8'h20);
    io_read(0, 8'h00, 1'b1);
    pins(1'b1, 1'b1);
    pulse(4);
    pins(1'b0, 1'b1);
    io_write(0, 8'h10);
    wait_cyc(3);
    pins(1'b1, 1'b1);
    mgmt_en <= 1'b1;
    io_write(4, 8'h00);
    pulse(2);
    pins(1'b1, 1'b0);
    io_write(0, 8'h20);
    wait_cyc(3);
    pins(1'b1, 1'b1);
    fw_en <= 1'b1;
    io_write(4, 8'h04);
    wait_cyc(3);
    pins(1'b1, 1'b0);
    check({7'h00, fw_status}, 8'h01);
    pulse(3);
    pins(1'b1, 1'b1);
    $display("test interrupts done");
    tick(300);
    io_read(8, 8'h2c, 1'b1);
    io_read(9, 8'h01, 1'b1);
    io_read(10, 8'h00, 1'b1);
    io_write(8, 8'hff);
    wait_cyc(100);
    io_read(8, 8'h2c, 1'b1);
    tick(4);
    io_read(8, 8'h30, 1'b1);
    $display("test timer done");
    pulse(0);
    io_read(1, 8'h00, 1'b1);
    all_sleep <= 1'b1;
    wait_cyc(3);
    check({7'h00, sleeping}, 8'h01);
    tick(4);
    io_read(8, 8'h30, 1'b1);
    pulse(0);
    check({7'h00, sleeping}, 8'h00);
    io_read(1, 8'h80, 1'b1);
    io_write(1, 8'h00);
    io_read(1, 8'h80, 1'b1);
    tick(2);
    io_read(8, 8'h32, 1'b1);
    io_write(1, 8'h80);
    io_read(1, 8'h00, 1'b1);
    check({7'h00, sleeping}, 8'h01);
    pulse(0);
    io_read(1, 8'h80, 1'b1);
    pulse(1);
    io_read(1, 8'h00, 1'b1);
    $display("test sleep done");
    end_sim();
  end
endmodule
